// ==== cfg_pins_pkg.sv ====
// Package: constants and types for the configuration control pin block
package cfg_pins_pkg;
  // Mode pin encodings (three mode inputs)
  localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h7;
  localparam logic [2:0] MODE_MASTER_PAR_UP = 3'h1;
  localparam logic [2:0] MODE_MASTER_PAR_DN = 3'h3;
  localparam logic [2:0] MODE_PERIPH_SYNC = 3'h5;
  localparam logic [2:0] MODE_PERIPH_ASYNC = 3'h4;
  // Memory clear sweep: frames per clear cycle
  localparam int CLEAR_FRAMES = 64;
  localparam logic [7:0] CLEAR_LAST = 8'(CLEAR_FRAMES - 1);
  localparam logic [7:0] CLEAR_ZERO = 8'h00;
  // Shift clock divider when the device makes the clock
  localparam int CLK_HZ = 25_000_000;
  localparam int SHIFT_HZ = 1_000_000;
  localparam int DIV_HALF = CLK_HZ / (2 * SHIFT_HZ);
  localparam logic [4:0] DIV_LAST = 5'(DIV_HALF - 1);
  localparam logic [4:0] DIV_ZERO = 5'h00;

  // Sequencer states, Gray along the normal path
  typedef enum logic [2:0] {
    ST_CLEAR = 3'h0,
    ST_CLEAR_LAST = 3'h1,
    ST_WAIT = 3'h3,
    ST_LOAD = 3'h2,
    ST_HOLD = 3'h6,
    ST_USER = 3'h7
  } cfg_state_t;

  // Status bundle toward the device core
  typedef struct packed {
    logic clearing;
    logic loading;
    logic gsr_hold;
    logic outputs_en;
  } cfg_status_t;
endpackage

// ==== config_control_pins.sv ====
// Configuration control pin sequencer: clear, mode sample, load, done
`timescale 1ns/1ps
module config_control_pins
  import cfg_pins_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  // Start input, active low
  input wire logic START_N_IN,
  // Mode select pins
  input wire logic [2:0] CONFIG_MODE_SELECT_PINS_IN,
  // Shift clock pin (three signals)
  input wire logic CONFIG_SHIFT_CLOCK_IN,
  output logic CONFIG_SHIFT_CLOCK_OUT,
  output logic CONFIG_SHIFT_CLOCK_OE_N_OUT,
  // Completion pin, open drain style (three signals)
  input wire logic DONE_IN,
  output logic DONE_OUT,
  output logic DONE_OE_N_OUT,
  // Ready pin, open drain: low while clearing
  output logic INIT_READY_OUT,
  output logic INIT_READY_OE_N_OUT,
  // Configuration options and loader handshake
  input wire logic WAIT_ON_DONE_IN,
  input wire logic READBACK_EN_IN,
  input wire logic LOAD_DONE_IN,
  // Status toward core
  output logic [2:0] MODE_OUT,
  output logic SHIFT_TICK_OUT,
  output logic READBACK_CLK_OUT,
  output cfg_status_t STATUS_OUT
);

  cfg_state_t state_q, state_d;
  logic [7:0] frame_q, frame_d;
  logic [2:0] mode_q, mode_d;
  logic [4:0] div_q, div_d;
  logic sclk_q, sclk_d;
  logic done_q, done_d;
  logic tick_q, tick_d;
  logic dev_clk;
  logic frame_end;

  // All checks below run on the reference clock, quiet during reset
  default clocking chk_cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  assign frame_end = (frame_q == CLEAR_LAST);

  // Device drives the clock in master and async peripheral modes
  always_comb begin
    dev_clk = (mode_q != MODE_SLAVE_SERIAL) &&
              (mode_q != MODE_PERIPH_SYNC);
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    frame_d = frame_q;
    mode_d = mode_q;
    done_d = done_q;
    // Each clear cycle sweeps every frame; a low start restarts nothing
    // mid-sweep so partial clears never leave stale frames behind
    frame_d = (state_q == ST_CLEAR || state_q == ST_CLEAR_LAST) ?
              (frame_end ? CLEAR_ZERO : frame_q + 8'h01) : CLEAR_ZERO;
    if (!START_N_IN) begin
      state_d = ST_CLEAR;
      done_d = 1'b0;
      if (state_q != ST_CLEAR && state_q != ST_CLEAR_LAST) begin
        frame_d = CLEAR_ZERO;
      end
    end else begin
      case (state_q)
        ST_CLEAR: begin
          if (frame_end) begin
            state_d = ST_CLEAR_LAST;
          end
        end
        ST_CLEAR_LAST: begin
          if (frame_end) begin
            state_d = ST_WAIT;
          end
        end
        ST_WAIT: begin
          mode_d = CONFIG_MODE_SELECT_PINS_IN;
          state_d = ST_LOAD;
        end
        ST_LOAD: begin
          if (LOAD_DONE_IN) begin
            done_d = 1'b1;
            state_d = ST_HOLD;
          end
        end
        ST_HOLD: begin
          // External party may keep completion low to delay start-up
          if (!WAIT_ON_DONE_IN || DONE_IN) begin
            state_d = ST_USER;
          end
        end
        ST_USER: begin
          state_d = ST_USER;
        end
        default: begin
          state_d = ST_CLEAR;
        end
      endcase
    end
  end

  // Shift clock divider; runs only while loading in device-clocked modes
  always_comb begin
    div_d = div_q;
    sclk_d = sclk_q;
    tick_d = 1'b0;
    if (state_q == ST_LOAD && dev_clk) begin
      if (div_q == DIV_LAST) begin
        div_d = DIV_ZERO;
        sclk_d = !sclk_q;
        tick_d = !sclk_q; // Rising edge of generated clock
      end else begin
        div_d = div_q + 5'h01;
      end
    end else begin
      div_d = DIV_ZERO;
      // Track the pin level outside device-clocked loading so the edge
      // detector starts at the idle level and gives no false first tick
      sclk_d = CONFIG_SHIFT_CLOCK_IN;
      // Slave modes take rising edges of the external clock pin as ticks
      tick_d = (state_q == ST_LOAD) && CONFIG_SHIFT_CLOCK_IN && !sclk_q;
    end
  end

  // Registers
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_q <= ST_CLEAR;
      frame_q <= CLEAR_ZERO;
      mode_q <= MODE_SLAVE_SERIAL;
      div_q <= DIV_ZERO;
      sclk_q <= 1'b0;
      done_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      state_q <= state_d;
      frame_q <= frame_d;
      mode_q <= mode_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      done_q <= done_d;
      tick_q <= tick_d;
    end
  end

  // Pin drivers
  always_comb begin
    CONFIG_SHIFT_CLOCK_OUT = sclk_q;
    // Drive only while loading in device-clocked modes
    CONFIG_SHIFT_CLOCK_OE_N_OUT = !(state_q == ST_LOAD && dev_clk);
    DONE_OUT = 1'b0;
    // Open drain: pull low until finished, then release to go high
    DONE_OE_N_OUT = done_q;
    INIT_READY_OUT = 1'b0;
    INIT_READY_OE_N_OUT = !(state_q == ST_CLEAR ||
                            state_q == ST_CLEAR_LAST);
    MODE_OUT = mode_q;
    SHIFT_TICK_OUT = tick_q;
    // After configuration the pin level feeds readback shifting
    READBACK_CLK_OUT = (state_q == ST_USER) && READBACK_EN_IN &&
                       CONFIG_SHIFT_CLOCK_IN;
    STATUS_OUT.clearing = (state_q == ST_CLEAR ||
                           state_q == ST_CLEAR_LAST);
    STATUS_OUT.loading = (state_q == ST_LOAD);
    STATUS_OUT.gsr_hold = (state_q != ST_USER);
    STATUS_OUT.outputs_en = (state_q == ST_USER);
  end

  // Completion never released before data accepted
  done_early_a: assert property (
    (state_q != ST_HOLD && state_q != ST_USER) |-> DONE_OE_N_OUT == 1'b0)
    else $error("completion released early");

  // Start low forces clearing next cycle
  start_clear_a: assert property (
    !START_N_IN |=> state_q == ST_CLEAR)
    else $error("start low did not clear");

  sequence last_sweep_s;
    state_q == ST_CLEAR_LAST && frame_end && START_N_IN;
  endsequence
  // Second clear ends in wait with ready released
  clear_wait_a: assert property (
    last_sweep_s |=> state_q == ST_WAIT && INIT_READY_OE_N_OUT)
    else $error("no wait after second clear");

  // Ready held low during clearing
  ready_low_a: assert property (
    STATUS_OUT.clearing |-> !INIT_READY_OE_N_OUT)
    else $error("ready released while clearing");

  // Ready rises only once the second sweep has run out; a sequencer
  // that skipped the extra clear cycle would trip this
  ready_rise_a: assert property (
    $rose(INIT_READY_OE_N_OUT) |->
    $past(state_q) == ST_CLEAR_LAST && $past(frame_end))
    else $error("ready released before full clear");

  // Mode captured from pins in wait state
  mode_sample_a: assert property (
    (state_q == ST_WAIT && START_N_IN) |=>
    mode_q == $past(CONFIG_MODE_SELECT_PINS_IN))
    else $error("mode not sampled");

  // Clock driven only in device-clocked modes
  clk_dir_a: assert property (
    !CONFIG_SHIFT_CLOCK_OE_N_OUT |-> (mode_q != MODE_SLAVE_SERIAL &&
    mode_q != MODE_PERIPH_SYNC))
    else $error("shift clock driven in slave mode");

  // Shift ticks only come out of a loading cycle
  tick_load_a: assert property (
    SHIFT_TICK_OUT |-> $past(state_q) == ST_LOAD)
    else $error("shift tick outside loading");

  // External low completion holds start-up
  done_hold_a: assert property (
    (state_q == ST_HOLD && WAIT_ON_DONE_IN && !DONE_IN && START_N_IN) |=>
    state_q == ST_HOLD && !STATUS_OUT.outputs_en)
    else $error("start-up not held");

  // Load accepted releases completion next cycle
  done_set_a: assert property (
    (state_q == ST_LOAD && LOAD_DONE_IN && START_N_IN) |=> DONE_OE_N_OUT)
    else $error("completion not signalled");

  // Readback clock only after configuration
  readback_a: assert property (
    READBACK_CLK_OUT |-> state_q == ST_USER && READBACK_EN_IN)
    else $error("readback clock outside user state");

endmodule // config_control_pins

// ==== cfg_host_model.sv ====
// Host-side model of the completion pin and shift clock pin wiring
`timescale 1ns/1ps
module cfg_host_model (
  // Clock and host controls
  input wire logic clk_in,
  input wire logic hold_done_in,
  input wire logic sclk_run_in,
  // Device pin drivers
  input wire logic done_oe_n_in,
  input wire logic sclk_oe_n_in,
  input wire logic sclk_dev_in,
  // Resolved wire levels
  output logic done_wire_out,
  output logic sclk_wire_out
);
  logic tog_q = 1'b1;
  // Host clock stands at the pull-up level outside its frames
  always_ff @(posedge clk_in) begin
    tog_q <= sclk_run_in ? ~tog_q : 1'b1;
  end
  // Wired-AND completion pin with pull-up; host may hold it low
  assign done_wire_out = done_oe_n_in & ~hold_done_in;
  // Device drives the clock pin when enabled, else the host does
  assign sclk_wire_out = !sclk_oe_n_in ? sclk_dev_in : tog_q;
endmodule // cfg_host_model

// ==== config_control_pins_tb_top.sv ====
// Self-checking testbench for the configuration control pin block
`timescale 1ns/1ps
module config_control_pins_tb_top;
  import cfg_pins_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start_n = 1'b1;
  logic [2:0] mode = 3'h7;
  logic wait_done = 1'b0;
  logic rb_en = 1'b0;
  logic load_done = 1'b0;
  logic hold = 1'b0;
  logic run = 1'b0;
  logic done_w, sclk_w, sclk_o, sclk_oe_n, done_oe_n, init_oe_n;
  logic rb_clk, tick, done_o, init_o;
  logic [2:0] mode_o;
  cfg_status_t st;
  int failures = 0;
  int n_tests = 0;
  int cnt;
  localparam logic [2:0] MODES [6] = '{MODE_MASTER_SERIAL, MODE_SLAVE_SERIAL,
    MODE_MASTER_PAR_UP, MODE_MASTER_PAR_DN, MODE_PERIPH_SYNC,
    MODE_PERIPH_ASYNC};
  // Clock at 25 MHz
  always #20 clk = ~clk;
  config_control_pins DUT (.REF_CLK_IN(clk), .RESET_IN(rst),
    .START_N_IN(start_n), .CONFIG_MODE_SELECT_PINS_IN(mode),
    .CONFIG_SHIFT_CLOCK_IN(sclk_w), .CONFIG_SHIFT_CLOCK_OUT(sclk_o),
    .CONFIG_SHIFT_CLOCK_OE_N_OUT(sclk_oe_n), .DONE_IN(done_w),
    .DONE_OUT(done_o), .DONE_OE_N_OUT(done_oe_n), .INIT_READY_OUT(init_o),
    .INIT_READY_OE_N_OUT(init_oe_n), .WAIT_ON_DONE_IN(wait_done),
    .READBACK_EN_IN(rb_en), .LOAD_DONE_IN(load_done), .MODE_OUT(mode_o),
    .SHIFT_TICK_OUT(tick), .READBACK_CLK_OUT(rb_clk), .STATUS_OUT(st));
  cfg_host_model host (.clk_in(clk), .hold_done_in(hold),
    .sclk_run_in(run), .done_oe_n_in(done_oe_n), .sclk_oe_n_in(sclk_oe_n),
    .sclk_dev_in(sclk_o), .done_wire_out(done_w), .sclk_wire_out(sclk_w));
  task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Sample just after an edge so registered outputs have settled
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic configure(logic [2:0] m);
    @(posedge clk) start_n <= 1'b0;
    mode <= m;
    cyc(3);
    check("clearing", 4'({init_oe_n, done_oe_n, st.clearing}), 4'h1);
    @(posedge clk) start_n <= 1'b1;
    cnt = 0;
    while (init_oe_n !== 1'b1 && cnt < 200) begin
      cyc(1);
      cnt++;
    end
    // Rest of the running sweep plus one full sweep
    check("clear span", 4'(cnt >= CLEAR_FRAMES &&
          cnt <= 2 * CLEAR_FRAMES + 2), 4'h1);
    check("done held", 4'(done_oe_n), 4'h0);
    cyc(2);
    check("mode", 4'(mode_o), 4'(m));
    // Host clock stands high here, so no shift tick may appear yet
    check("no tick", 4'(tick), 4'h0);
    check("loading", st, 4'h6);
  endtask
  task automatic finish_load();
    @(posedge clk) load_done <= 1'b1;
    @(posedge clk) load_done <= 1'b0;
    cyc(3);
  endtask
  // Every mode: sampled mode, clock pin direction, completion
  task automatic t_modes();
    foreach (MODES[i]) begin
      configure(MODES[i]);
      check("clk dir", 4'(sclk_oe_n),
            4'(MODES[i] inside {MODE_SLAVE_SERIAL, MODE_PERIPH_SYNC}));
      finish_load();
      check("done", 4'({done_oe_n, st.outputs_en}), 4'h3);
    end
    $display("test modes done");
  endtask
  // Host holds completion low: start-up waits for it
  task automatic t_hold_done();
    @(posedge clk) wait_done <= 1'b1;
    hold <= 1'b1;
    configure(MODE_SLAVE_SERIAL);
    finish_load();
    cyc(8);
    check("held", 4'({st.gsr_hold, st.outputs_en}), 4'h2);
    @(posedge clk) hold <= 1'b0;
    cyc(3);
    check("freed", 4'({st.gsr_hold, st.outputs_en}), 4'h1);
    $display("test hold done");
  endtask
  // Readback clock follows the pin only when selected
  task automatic t_readback();
    @(posedge clk) run <= 1'b1;
    rb_en <= 1'b1;
    repeat (4) begin
      cyc(1);
      check("rb clk", 4'(rb_clk), 4'(sclk_w));
    end
    @(posedge clk) rb_en <= 1'b0;
    cyc(2);
    check("rb off", 4'(rb_clk), 4'h0);
    @(posedge clk) run <= 1'b0;
    $display("test readback done");
  endtask
  // Master serial: the device makes the shift clock at its set rate
  task automatic t_shift_clock();
    int ticks;
    int edges;
    logic last;
    ticks = 0;
    edges = 0;
    configure(MODE_MASTER_SERIAL);
    last = sclk_w;
    // Window of five half periods: five pin edges, two rising ticks
    repeat (5 * DIV_HALF) begin
      cyc(1);
      if (tick === 1'b1) begin
        ticks++;
      end
      if (sclk_w !== last) begin
        edges++;
      end
      last = sclk_w;
    end
    check("ticks", 4'(ticks), 4'h2);
    check("clk edges", 4'(edges), 4'h5);
    finish_load();
    $display("test shift clock done");
  endtask
  // Reset in mid-run: pins go back to reset levels, then two sweeps
  task automatic t_reset();
    @(posedge clk) rst <= 1'b1;
    cyc(2);
    check("rst pins", 4'({init_oe_n, done_oe_n, sclk_oe_n}), 4'h1);
    check("rst mode", 4'(mode_o), 4'(MODE_SLAVE_SERIAL));
    check("rst status", st, 4'ha);
    check("drive lows", 4'({done_o, init_o}), 4'h0);
    @(posedge clk) rst <= 1'b0;
    cnt = 0;
    while (init_oe_n !== 1'b1 && cnt < 200) begin
      cyc(1);
      cnt++;
    end
    check("rst span", 4'(cnt == 2 * CLEAR_FRAMES), 4'h1);
    $display("test reset done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence after reset
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_modes();
    t_hold_done();
    t_readback();
    t_shift_clock();
    t_reset();
    give_verdict();
  end
  // Watchdog: the run needs about 1300 cycles
  initial begin
    #200_000;
    failures++;
    give_verdict();
  end
endmodule // config_control_pins_tb_top
